/* rtl/rcc_pkg.sv */
// Purpose : Shared constants and carriers for the regulator and clock config bank
// Assumes : 16-bit register data word, bit 0 of the word is register bit 8
// Notes   : Register select codes are local to this block

package rcc_pkg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  localparam logic REG_SEL_CTRL2 = 1'b0;
  localparam logic REG_SEL_CLOCK = 1'b1;

  // ----------------------------------------------------------------
  // Thermal and drive register field positions (word bits)
  // ----------------------------------------------------------------
  localparam int CORE_TSD_POS   = 12;
  localparam int SECOND_TSD_POS = 10;
  localparam int LINEAR_TSD_POS = 9;
  localparam int LS_DRIVE_LSB   = 3;
  localparam int HS_DRIVE_LSB   = 0;

  // ----------------------------------------------------------------
  // Clock register field positions (word bits)
  // ----------------------------------------------------------------
  localparam int SPREAD_PROF_POS = 15;
  localparam int MUX_SEL_LSB     = 11;
  localparam int PHASE_LSB       = 8;
  localparam int SRC_SEL_POS     = 7;
  localparam int EXT_REQ_POS     = 6;
  localparam int EXT_DIV_POS     = 5;
  localparam int SSM_EN_POS      = 4;
  localparam int TUNE_LSB        = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  LS_DRIVE_RST = 2'h3;
  localparam logic [1:0]  HS_DRIVE_RST = 2'h0;
  localparam logic [2:0]  TSD_CFG_RST  = 3'h0;
  localparam logic [15:0] CLOCK_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PHASE_STEP_NS  = 50;
  localparam int PHASE_STEP_CYC = (PHASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_MAX      = 7;
  localparam int EXT_DIV_RATIO  = 6;
  localparam logic [1:0] EXT_HALF_LAST = 2'((EXT_DIV_RATIO / 2) - 1);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       core_buck_thermal_behaviour;
    logic       second_buck_thermal_behaviour;
    logic       linear_reg_thermal_behaviour;
    logic [1:0] prereg_low_side_drive;
    logic [1:0] prereg_high_side_drive;
  } rcc_reg_cfg_s;

  typedef struct packed {
    logic       spread_profile_select;
    logic [3:0] sync_out_mux_select;
    logic [2:0] sync_out_phase_shift;
    logic       sync_out_source_select;
    logic       ext_input_divider;
    logic       spread_spectrum_enable;
    logic [3:0] clk_tune;
  } rcc_clk_cfg_s;

endpackage

/* rtl/rcc_phase_delay.sv */
// Purpose : Delays the selected sync clock by a programmable number of cycles
// Assumes : Input is a level sampled on mclk_in
// Notes   : One fixed pipeline stage sits ahead of the programmable delay and one after it

`timescale 1ns/1ps

module rcc_phase_delay
  import rcc_pkg::*;
(
  input  wire logic       mclk_in,    // System clock
  input  wire logic       arst_n_in,  // Async reset, active low
  input  wire logic       din_in,     // Selected clock level
  input  wire logic [2:0] phase_in,   // Delay in cycles
  output logic            dout_out    // Delayed clock level
);

  logic [PHASE_MAX:0] taps_r;
  logic               dout_r;
  wire  logic         tap_sel;

  assign tap_sel  = taps_r[phase_in];
  assign dout_out = dout_r;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      taps_r <= '0;
      dout_r <= 1'b0;
    end
    else
    begin
      taps_r <= {taps_r[PHASE_MAX-1:0], din_in};
      dout_r <= tap_sel;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence phase_held_zero_s;
    (phase_in == 3'h0) [*2];
  endsequence

  sequence phase_held_max_s;
    (phase_in == 3'h7) [*8];
  endsequence

  phase_zero_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    phase_held_zero_s |=> dout_out == $past(din_in, 2))
    else $error("No-shift path latency wrong");

  phase_max_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    phase_held_max_s |=> dout_out == $past(din_in, 9))
    else $error("Seven-cycle shift latency wrong");

endmodule // rcc_phase_delay

/* rtl/rcc_config_regs.sv */
// Purpose : Regulator thermal/drive and clock sync configuration registers
// Assumes : Frame decoder presents one 16-bit register word per access
// Notes   : OTP values are captured on the first edge after reset release

`timescale 1ns/1ps

module rcc_config_regs
  import rcc_pkg::*;
(
  input  wire logic        mclk_in,                 // 20 MHz system clock
  input  wire logic        arst_n_in,               // Async reset, active low
  input  wire logic        wr_en_in,                // Register write strobe
  input  wire logic        rd_en_in,                // Register read strobe
  input  wire logic        reg_sel_in,              // 0 thermal/drive, 1 clock
  input  wire logic [15:0] wr_data_in,              // Write word
  output logic      [15:0] rd_data_out,             // Read word
  input  wire logic [2:0]  otp_thermal_in,          // OTP core, second, linear
  input  wire logic [1:0]  otp_hs_drive_in,         // OTP high-side drive
  input  wire logic [2:0]  thermal_shutdown_in,     // Core, second, linear events
  output logic      [2:0]  reg_shutdown_out,        // Per-regulator shutdown
  output logic             deep_fail_safe_req_out,  // Deep fail-safe request
  output logic      [1:0]  prereg_low_side_drive_out,   // Low-side drive code
  output logic      [1:0]  prereg_high_side_drive_out,  // High-side drive code
  output logic             spread_profile_select_out,   // 0 23 kHz, 1 94 kHz
  output logic             spread_spectrum_enable_out,  // Modulation on
  output logic      [3:0]  sync_out_mux_select_out,     // Output mux code
  output logic      [3:0]  clk_tune_out,                // Oscillator tune code
  input  wire logic        first_internal_clock_in,     // First clock source
  input  wire logic        second_internal_clock_in,    // Second clock source
  output logic             sync_clock_output_out,       // Phase-shifted sync clock
  output logic             ext_input_select_request_out,// One-cycle request
  input  wire logic        sync_clock_input_in,         // External sync input
  output logic             sync_clock_input_div_out     // Divided sync input
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rcc_reg_cfg_s  reg_cfg_r;
  rcc_reg_cfg_s  reg_cfg_nxt;
  rcc_clk_cfg_s  clk_cfg_r;
  rcc_clk_cfg_s  clk_cfg_nxt;
  logic          otp_load_r;
  logic [15:0]   rd_data_r;
  logic [2:0]    shutdown_r;
  logic          deep_fail_safe_state_r;
  logic          ext_req_r;
  logic          src_clk_r;
  logic          fin_prev_r;
  logic [1:0]    fin_cnt_r;
  logic          ext_input_divider_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic        wr_ctrl2;
  wire logic        wr_clock;
  wire logic [2:0]  tsd_cfg;
  wire logic        deep_fail_safe_state_nxt;
  wire logic        src_clk_nxt;
  wire logic        fin_rise;
  wire logic        fin_half_done;
  wire logic [15:0] rd_mux;

  assign wr_ctrl2 = wr_en_in && (reg_sel_in == REG_SEL_CTRL2);
  assign wr_clock = wr_en_in && (reg_sel_in == REG_SEL_CLOCK);

  assign tsd_cfg = {reg_cfg_r.core_buck_thermal_behaviour,
                    reg_cfg_r.second_buck_thermal_behaviour,
                    reg_cfg_r.linear_reg_thermal_behaviour};
  assign deep_fail_safe_state_nxt = |(thermal_shutdown_in & tsd_cfg);

  assign src_clk_nxt = clk_cfg_r.sync_out_source_select ? second_internal_clock_in
                                                        : first_internal_clock_in;

  assign fin_rise      = sync_clock_input_in && !fin_prev_r;
  assign fin_half_done = (fin_cnt_r == EXT_HALF_LAST);

  // Packs a register image for reads; reserved and request bits stay zero
  function automatic logic [15:0] pack_word(input logic sel,
                                            input rcc_reg_cfg_s rc,
                                            input rcc_clk_cfg_s cc);
    logic [15:0] w;
    w = 16'h0000;
    if (sel == REG_SEL_CTRL2)
    begin
      w[CORE_TSD_POS]                  = rc.core_buck_thermal_behaviour;
      w[SECOND_TSD_POS]                = rc.second_buck_thermal_behaviour;
      w[LINEAR_TSD_POS]                = rc.linear_reg_thermal_behaviour;
      w[LS_DRIVE_LSB +: 2]             = rc.prereg_low_side_drive;
      w[HS_DRIVE_LSB +: 2]             = rc.prereg_high_side_drive;
    end
    else
    begin
      w[SPREAD_PROF_POS]               = cc.spread_profile_select;
      w[MUX_SEL_LSB +: 4]              = cc.sync_out_mux_select;
      w[PHASE_LSB +: 3]                = cc.sync_out_phase_shift;
      w[SRC_SEL_POS]                   = cc.sync_out_source_select;
      w[EXT_DIV_POS]                   = cc.ext_input_divider;
      w[SSM_EN_POS]                    = cc.spread_spectrum_enable;
      w[TUNE_LSB +: 4]                 = cc.clk_tune;
    end
    return w;
  endfunction

  assign rd_mux = pack_word(reg_sel_in, reg_cfg_r, clk_cfg_r);

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_cfg_nxt = reg_cfg_r;
    clk_cfg_nxt = clk_cfg_r;
    if (otp_load_r)
    begin
      reg_cfg_nxt.core_buck_thermal_behaviour   = otp_thermal_in[2];
      reg_cfg_nxt.second_buck_thermal_behaviour = otp_thermal_in[1];
      reg_cfg_nxt.linear_reg_thermal_behaviour  = otp_thermal_in[0];
      reg_cfg_nxt.prereg_high_side_drive        = otp_hs_drive_in;
    end
    else if (wr_ctrl2)
    begin
      reg_cfg_nxt.core_buck_thermal_behaviour   = wr_data_in[CORE_TSD_POS];
      reg_cfg_nxt.second_buck_thermal_behaviour = wr_data_in[SECOND_TSD_POS];
      reg_cfg_nxt.linear_reg_thermal_behaviour  = wr_data_in[LINEAR_TSD_POS];
      reg_cfg_nxt.prereg_low_side_drive         = wr_data_in[LS_DRIVE_LSB +: 2];
      reg_cfg_nxt.prereg_high_side_drive        = wr_data_in[HS_DRIVE_LSB +: 2];
    end
    if (wr_clock)
    begin
      clk_cfg_nxt.spread_profile_select  = wr_data_in[SPREAD_PROF_POS];
      clk_cfg_nxt.sync_out_mux_select    = wr_data_in[MUX_SEL_LSB +: 4];
      clk_cfg_nxt.sync_out_phase_shift   = wr_data_in[PHASE_LSB +: 3];
      clk_cfg_nxt.sync_out_source_select = wr_data_in[SRC_SEL_POS];
      clk_cfg_nxt.ext_input_divider      = wr_data_in[EXT_DIV_POS];
      clk_cfg_nxt.spread_spectrum_enable = wr_data_in[SSM_EN_POS];
      clk_cfg_nxt.clk_tune               = wr_data_in[TUNE_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_cfg_r  <= '{TSD_CFG_RST[2], TSD_CFG_RST[1], TSD_CFG_RST[0],
                      LS_DRIVE_RST, HS_DRIVE_RST};
      clk_cfg_r  <= rcc_clk_cfg_s'(CLOCK_RST[14:0]);
      otp_load_r <= 1'b1;
      rd_data_r  <= 16'h0000;
    end
    else
    begin
      reg_cfg_r  <= reg_cfg_nxt;
      clk_cfg_r  <= clk_cfg_nxt;
      otp_load_r <= 1'b0;
      if (rd_en_in)
      begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Thermal reaction and the write-one request
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shutdown_r <= 3'h0;
      deep_fail_safe_state_r  <= 1'b0;
      ext_req_r  <= 1'b0;
      src_clk_r  <= 1'b0;
    end
    else
    begin
      shutdown_r <= thermal_shutdown_in;
      deep_fail_safe_state_r  <= deep_fail_safe_state_nxt;
      ext_req_r  <= wr_clock && wr_data_in[EXT_REQ_POS];
      src_clk_r  <= src_clk_nxt;
    end
  end

  // External sync input divider: toggle every third rise for divide by six
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fin_prev_r <= 1'b0;
      fin_cnt_r  <= 2'h0;
      ext_input_divider_r  <= 1'b0;
    end
    else
    begin
      fin_prev_r <= sync_clock_input_in;
      if (!clk_cfg_r.ext_input_divider)
      begin
        fin_cnt_r <= 2'h0;
        ext_input_divider_r <= sync_clock_input_in;
      end
      else if (fin_rise)
      begin
        fin_cnt_r <= fin_half_done ? 2'h0 : fin_cnt_r + 2'h1;
        if (fin_half_done)
        begin
          ext_input_divider_r <= !ext_input_divider_r;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync clock phase shift
  // ----------------------------------------------------------------
  rcc_phase_delay u_phase_delay (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .din_in    (src_clk_r),
    .phase_in  (clk_cfg_r.sync_out_phase_shift),
    .dout_out  (sync_clock_output_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_out                  = rd_data_r;
  assign reg_shutdown_out             = shutdown_r;
  assign deep_fail_safe_req_out       = deep_fail_safe_state_r;
  assign prereg_low_side_drive_out    = reg_cfg_r.prereg_low_side_drive;
  assign prereg_high_side_drive_out   = reg_cfg_r.prereg_high_side_drive;
  assign spread_profile_select_out    = clk_cfg_r.spread_profile_select;
  assign spread_spectrum_enable_out   = clk_cfg_r.spread_spectrum_enable;
  assign sync_out_mux_select_out      = clk_cfg_r.sync_out_mux_select;
  assign clk_tune_out                 = clk_cfg_r.clk_tune;
  assign ext_input_select_request_out = ext_req_r;
  assign sync_clock_input_div_out     = ext_input_divider_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence ctrl2_write_s;
    wr_ctrl2 && !otp_load_r;
  endsequence

  sequence clock_write_s;
    wr_clock;
  endsequence

  core_tsd_a: assert property (
    thermal_shutdown_in[2] && reg_cfg_r.core_buck_thermal_behaviour
      |=> deep_fail_safe_req_out && reg_shutdown_out[2])
    else $error("Core buck shutdown did not force deep fail-safe");

  second_tsd_a: assert property (
    thermal_shutdown_in[1] && reg_cfg_r.second_buck_thermal_behaviour
      |=> deep_fail_safe_req_out && reg_shutdown_out[1])
    else $error("Second buck shutdown did not force deep fail-safe");

  linear_tsd_a: assert property (
    thermal_shutdown_in[0] && !reg_cfg_r.linear_reg_thermal_behaviour
      && !thermal_shutdown_in[2] && !thermal_shutdown_in[1]
      |=> !deep_fail_safe_req_out && reg_shutdown_out[0])
    else $error("Linear shutdown alone raised deep fail-safe");

  low_drive_a: assert property (
    ctrl2_write_s |=> prereg_low_side_drive_out == $past(wr_data_in[4:3]))
    else $error("Low-side drive not written");

  high_drive_a: assert property (
    ctrl2_write_s |=> prereg_high_side_drive_out == $past(wr_data_in[1:0]))
    else $error("High-side drive not written");

  spread_prof_a: assert property (
    clock_write_s ##1 !wr_clock [*2]
      |-> spread_profile_select_out == $past(wr_data_in[SPREAD_PROF_POS], 2))
    else $error("Spread profile not held after write");

  sync_src_a: assert property (
    $stable(clk_cfg_r.sync_out_source_select) |=>
      src_clk_r == ($past(clk_cfg_r.sync_out_source_select) ?
                    $past(second_internal_clock_in) : $past(first_internal_clock_in)))
    else $error("Sync source select wrong");

  ext_req_a: assert property (
    clock_write_s |=> ext_input_select_request_out == $past(wr_data_in[6]) ##1
      (ext_input_select_request_out == $past(wr_clock && wr_data_in[6])))
    else $error("External select request pulse wrong");

  div_one_a: assert property (
    !clk_cfg_r.ext_input_divider |=> sync_clock_input_div_out == $past(sync_clock_input_in))
    else $error("Divide-by-one path wrong");

  ssm_en_a: assert property (
    clock_write_s |=> spread_spectrum_enable_out == $past(wr_data_in[4]))
    else $error("Spread enable not written");

  otp_load_a: assert property (
    otp_load_r |=> reg_cfg_r.core_buck_thermal_behaviour == $past(otp_thermal_in[2])
      && prereg_high_side_drive_out == $past(otp_hs_drive_in)
      && prereg_low_side_drive_out == LS_DRIVE_RST)
    else $error("OTP load after reset wrong");

  rsvd_read_a: assert property (
    rd_en_in && (reg_sel_in == REG_SEL_CLOCK) |=> rd_data_out[6] == 1'b0)
    else $error("Request bit read back non-zero");

  rsvd_ctrl2_a: assert property (
    rd_en_in && (reg_sel_in == REG_SEL_CTRL2) |=> (rd_data_out & 16'hE9E4) == 16'h0000)
    else $error("Reserved thermal/drive bits read non-zero");

endmodule // rcc_config_regs

/* verif/rcc_host_model.sv */
// Purpose : Host side of the register port, one strobe per access
// Assumes : Strobes are driven at the falling edge and held for one cycle
// Notes   : Write data is inverted after each write so stale data never helps

`timescale 1ns/1ps

module rcc_host_model (
  input  wire logic        clk_in,     // System clock
  input  wire logic [15:0] rd_data_in, // Read word from the bank
  output logic             wr_en_out,  // Write strobe
  output logic             rd_en_out,  // Read strobe
  output logic             sel_out,    // Register select
  output logic      [15:0] data_out    // Write word
);
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    sel_out   = 1'b0;
    data_out  = 16'h0000;
  end

  task automatic wr(input logic s, input logic [15:0] d);
    @(negedge clk_in);
    sel_out   = s;
    data_out  = d;
    wr_en_out = 1'b1;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    data_out  = ~d;
  endtask

  task automatic rd(input logic s, output logic [15:0] d);
    @(negedge clk_in);
    sel_out   = s;
    rd_en_out = 1'b1;
    @(negedge clk_in);
    rd_en_out = 1'b0;
    sel_out   = ~s;
    d         = rd_data_in;
  endtask
endmodule // rcc_host_model

/* verif/tb.sv */
// Purpose : Self-checking bench for the regulator and clock config bank
// Assumes : Outputs are sampled at the falling edge, half a cycle after the taking edge
// Notes   : Random values come from an xorshift generator seeded with 82425

`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb;
  import rcc_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr_en, rd_en, sel, deep, prof, ssen, c1, c2, sout, req, sin, sdiv, last;
  logic [15:0] wdata, rdata, r, d;
  logic [2:0]  otp_th, thermal_shutdown, rsd;
  logic [1:0]  otp_hs, ls, hs;
  logic [3:0]  mux, tune;
  logic [31:0] rng = 32'h0001_41F9;
  logic [31:0] t;
  logic        hist [0:31];
  int          err_total = 0;
  int          n_checks = 0;
  int          tg;

  always #25 clk = ~clk;

  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Deep fail-safe is expected when any event meets a set behaviour bit
  function automatic logic exp_deep(input logic [2:0] ev, input logic [15:0] w);
    return |(ev & {w[CORE_TSD_POS], w[SECOND_TSD_POS], w[LINEAR_TSD_POS]});
  endfunction

  rcc_host_model host (.clk_in(clk), .rd_data_in(rdata), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .sel_out(sel), .data_out(wdata));

  rcc_config_regs dut (.mclk_in(clk), .arst_n_in(arst_n), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .reg_sel_in(sel), .wr_data_in(wdata), .rd_data_out(rdata),
    .otp_thermal_in(otp_th), .otp_hs_drive_in(otp_hs), .thermal_shutdown_in(thermal_shutdown),
    .reg_shutdown_out(rsd), .deep_fail_safe_req_out(deep),
    .prereg_low_side_drive_out(ls), .prereg_high_side_drive_out(hs),
    .spread_profile_select_out(prof), .spread_spectrum_enable_out(ssen),
    .sync_out_mux_select_out(mux), .clk_tune_out(tune),
    .first_internal_clock_in(c1), .second_internal_clock_in(c2),
    .sync_clock_output_out(sout), .ext_input_select_request_out(req),
    .sync_clock_input_in(sin), .sync_clock_input_div_out(sdiv));

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    thermal_shutdown = 3'h0; c1 = 1'b0; c2 = 1'b0; sin = 1'b0;
    t = nxt();
    otp_th = t[2:0];
    otp_hs = t[4:3];
    repeat (10) @(negedge clk);
    `CHK("ls_in_reset", 2'h3, ls)
    `CHK("deep_in_reset", 1'b0, deep)
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    host.rd(1'b0, r);
    `CHK("reg0_reset", {3'h0, otp_th[2], 1'b0, otp_th[1:0], 4'h0, 2'h3, 1'b0, otp_hs}, r)
    host.rd(1'b1, r);
    `CHK("reg1_reset", 16'h0000, r)
    // Thermal and drive register with thermal events
    for (int i = 0; i < 10; i++)
    begin
      t = nxt();
      d = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hFFFF : t[15:0]);
      host.wr(1'b0, d);
      `CHK("low_side", d[4:3], ls)
      `CHK("high_side", d[1:0], hs)
      host.rd(1'b0, r);
      `CHK("reg0_read", d & 16'h161B, r)
      for (int k = 0; k < 5; k++)
      begin
        t = nxt();
        thermal_shutdown = (k == 0) ? 3'h7 : ((k == 1) ? 3'h1 : t[2:0]);
        @(negedge clk);
        `CHK("shutdown", thermal_shutdown, rsd)
        `CHK("deep_req", exp_deep(thermal_shutdown, d), deep)
      end
      thermal_shutdown = 3'h0;
    end
    // Request pulse and write-only bit
    host.wr(1'b1, 16'hFFFF);
    `CHK("req_pulse", 1'b1, req)
    @(negedge clk);
    `CHK("req_end", 1'b0, req)
    host.rd(1'b1, r);
    `CHK("reg1_all", 16'hFFBF, r)
    host.wr(1'b1, 16'h0000);
    `CHK("req_zero", 1'b0, req)
    // Clock register fields and sync output for every source and phase
    for (int s = 0; s < 2; s++)
    begin
      for (int ph = 0; ph < 8; ph++)
      begin
        t = nxt();
        d = (t[15:0] & 16'hF83F) | (16'(ph) << 8) | (16'(s) << 7);
        host.wr(1'b1, d);
        `CHK("profile", d[15], prof)
        `CHK("spread_en", d[4], ssen)
        `CHK("mux_tune", {d[14:11], d[3:0]}, {mux, tune})
        host.rd(1'b1, r);
        `CHK("reg1_read", d, r)
        for (int j = 0; j < 24; j++)
        begin
          @(negedge clk);
          if (j >= ph + 3)
            `CHK("sync_out", hist[j - ph - 3], sout)
          t = nxt();
          c1 = t[0];
          c2 = t[1];
          hist[j] = (s == 1) ? t[1] : t[0];
        end
      end
    end
    // Divider by one, then by six
    host.wr(1'b1, 16'h0000);
    for (int j = 0; j < 12; j++)
    begin
      @(negedge clk);
      if (j > 0)
        `CHK("div1", last, sdiv)
      t = nxt();
      sin = (j < 11) && t[0];
      last = sin;
    end
    host.wr(1'b1, 16'h0020);
    tg = 0;
    last = sdiv;
    for (int j = 0; j < 64; j++)
    begin
      @(negedge clk);
      if (sdiv !== last)
        tg++;
      last = sdiv;
      sin = (j < 60) && (j % 2 == 0);
    end
    `CHK("div6_toggles", 10, tg)
    // Mid-run reset brings back the reset image and the OTP load
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("ls_mid_reset", LS_DRIVE_RST, ls)
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("hs_mid_reset", otp_hs, hs)
    host.rd(1'b1, r);
    `CHK("reg1_mid_reset", 16'h0000, r)
    summarize();
  end
endmodule // tb
